// >>> hdl/adcp_top.sv
`include "adcp_defs.svh"
module adcp_top #(
    parameter int EE_BYTES = 16
) (
    // clock and reset
    input  wire logic                 clk_i,
    input  wire logic                 resetn_i,
    // two-wire pins
    input  wire logic                 scl_i,
    input  wire logic                 sda_i,
    output logic                      scl_o,
    output logic                      scl_oe_o,
    output logic                      sda_o,
    output logic                      sda_oe_o,
    // straps and switches
    input  wire logic                 address_select_pin_i,
    input  wire logic                 flat_eq_pin_i,
    // coefficient fetch
    input  wire logic [6:0]           coef_addr_i,
    output logic [23:0]               coef_o,
    // sample path
    input  wire logic signed [23:0]   audio_i,
    input  wire logic [23:0]          comp_scale_i,
    output logic signed [23:0]        audio_o,
    // control outputs
    output adcp_pkg::adcp_scfg_type   serial_cfg_o,
    output logic                      tone_download_o,
    output logic                      flat_eq_o,
    output logic                      slave_mode_o,
    output logic [63:0]               range_compressor_o
);
    function automatic logic [3:0] blen(input logic [7:0] s);
        if (s == `ADCP_CTL1_OFS || s == `ADCP_CTL2_OFS) blen = 4'h1;
        else if (s == `ADCP_COMP_OFS) blen = `ADCP_COMP_LEN;
        else if (s >= `ADCP_BQL_OFS && s < `ADCP_BQL_OFS + 8'h07) blen = `ADCP_BQ_LEN;
        else if (s >= `ADCP_BQR_OFS && s < `ADCP_BQR_OFS + 8'h07) blen = `ADCP_BQ_LEN;
        else blen = 4'h0;
    endfunction : blen

    // pin synchronisers
    wire [3:0] pin_w = {flat_eq_pin_i, address_select_pin_i, sda_i, scl_i};
    logic [2:0] sy_reg [4];
    logic [3:0] flt_reg;
    logic [3:0] fd_reg;
    genvar g;
    for (g = 0; g < 4; g++) begin : g_sync
        always_ff @(posedge clk_i or negedge resetn_i) begin
            if (!resetn_i) begin
                sy_reg[g]  <= (g < 2) ? 3'h7 : 3'h0;
                flt_reg[g] <= (g < 2);
                fd_reg[g]  <= (g < 2);
            end else begin
                sy_reg[g] <= {sy_reg[g][1:0], pin_w[g]};
                if (sy_reg[g][1] == sy_reg[g][2]) flt_reg[g] <= sy_reg[g][2];
                fd_reg[g] <= flt_reg[g];
            end
        end
    end
    wire scl_f = flt_reg[0];
    wire sda_f = flt_reg[1];
    wire scl_rise = scl_f & ~fd_reg[0];
    wire scl_fall = ~scl_f & fd_reg[0];
    wire start_w = scl_f & fd_reg[0] & ~sda_f & fd_reg[1];
    wire stop_w = scl_f & fd_reg[0] & sda_f & ~fd_reg[1];

    // startup master toward the eeprom
    adcp_pkg::adcp_mst_type mst_reg;
    logic [8:0] mcnt_reg;
    logic [1:0] mq_reg;
    logic [3:0] mbit_reg;
    logic [7:0] msh_reg;
    logic [7:0] mnb_reg;
    logic       mack_reg;
    logic       mscl_reg;
    logic       msda_reg;
    logic       mbv_reg;
    wire mtick = (mcnt_reg == 9'(`ADCP_QTR_CYC - 1));
    wire mlast = (mnb_reg == 8'(EE_BYTES - 1));
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            mst_reg <= adcp_pkg::M_START;
            mcnt_reg <= 9'h000;
            mq_reg <= 2'h0;
            mbit_reg <= 4'h0;
            msh_reg <= 8'h00;
            mnb_reg <= 8'h00;
            mack_reg <= 1'b0;
            mscl_reg <= 1'b0;
            msda_reg <= 1'b0;
            mbv_reg <= 1'b0;
        end else begin
            mbv_reg <= 1'b0;
            mcnt_reg <= mtick ? 9'h000 : mcnt_reg + 9'h001;
            if (mtick && mst_reg != adcp_pkg::M_OFF) begin
                mq_reg <= mq_reg + 2'h1;
                case (mst_reg)
                    adcp_pkg::M_START: begin
                        if (mq_reg == 2'h1) msda_reg <= 1'b1;
                        if (mq_reg == 2'h2) mscl_reg <= 1'b1;
                        if (mq_reg == 2'h3) begin
                            mst_reg <= adcp_pkg::M_TX;
                            msh_reg <= {`ADCP_EE_ADDR, 1'b1};
                        end
                    end
                    adcp_pkg::M_TX: begin
                        if (mq_reg == 2'h0) msda_reg <= (mbit_reg < 4'h8) & ~msh_reg[7];
                        if (mq_reg == 2'h1) mscl_reg <= 1'b0;
                        if (mq_reg == 2'h2) mack_reg <= ~sda_f;
                        if (mq_reg == 2'h3) begin
                            mscl_reg <= 1'b1;
                            mbit_reg <= mbit_reg + 4'h1;
                            msh_reg <= {msh_reg[6:0], 1'b0};
                            if (mbit_reg == 4'h8) begin
                                mbit_reg <= 4'h0;
                                mst_reg <= mack_reg ? adcp_pkg::M_RX : adcp_pkg::M_STOP;
                            end
                        end
                    end
                    adcp_pkg::M_RX: begin
                        if (mq_reg == 2'h0) msda_reg <= (mbit_reg == 4'h8) & ~mlast;
                        if (mq_reg == 2'h1) mscl_reg <= 1'b0;
                        if (mq_reg == 2'h2 && mbit_reg < 4'h8) msh_reg <= {msh_reg[6:0], sda_f};
                        if (mq_reg == 2'h3) begin
                            mscl_reg <= 1'b1;
                            mbit_reg <= mbit_reg + 4'h1;
                            mbv_reg <= (mbit_reg == 4'h7);
                            if (mbit_reg == 4'h8) begin
                                mbit_reg <= 4'h0;
                                mnb_reg <= mnb_reg + 8'h01;
                                if (mlast) mst_reg <= adcp_pkg::M_STOP;
                            end
                        end
                    end
                    adcp_pkg::M_STOP: begin
                        if (mq_reg == 2'h0) msda_reg <= 1'b1;
                        if (mq_reg == 2'h1) mscl_reg <= 1'b0;
                        if (mq_reg == 2'h2) msda_reg <= 1'b0;
                        if (mq_reg == 2'h3) mst_reg <= adcp_pkg::M_OFF;
                    end
                    default: mst_reg <= adcp_pkg::M_OFF;
                endcase
            end
        end
    end
    wire slv_en = (mst_reg == adcp_pkg::M_OFF);

    // slave engine
    adcp_pkg::adcp_sst_type sst_reg;
    logic [3:0] sbit_reg;
    logic [7:0] ssh_reg;
    logic       srd_reg;
    logic       ssda_reg;
    logic       sbv_reg;
    logic [7:0] sub_reg;
    logic [7:0] ctl1_reg;
    logic [7:0] ctl2_reg;
    wire adr_hit = (ssh_reg[7:1] == {`ADCP_SLV_HI, flt_reg[2]});
    wire [7:0] rd_w = (sub_reg == `ADCP_CTL1_OFS) ? (ctl1_reg & `ADCP_CTL1_WMSK) :
                      (sub_reg == `ADCP_CTL2_OFS) ? (ctl2_reg & `ADCP_CTL2_WMSK) : 8'h00;
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            sst_reg <= adcp_pkg::S_IDLE;
            sbit_reg <= 4'h0;
            ssh_reg <= 8'h00;
            srd_reg <= 1'b0;
            ssda_reg <= 1'b0;
            sbv_reg <= 1'b0;
        end else begin
            sbv_reg <= 1'b0;
            if (!slv_en || stop_w) begin
                sst_reg <= adcp_pkg::S_IDLE;
                ssda_reg <= 1'b0;
            end else if (start_w) begin
                sst_reg <= adcp_pkg::S_ADDR;
                sbit_reg <= 4'h0;
                ssda_reg <= 1'b0;
            end else if (scl_rise) begin
                if (sst_reg == adcp_pkg::S_ADDR || sst_reg == adcp_pkg::S_WDAT) begin
                    ssh_reg <= {ssh_reg[6:0], sda_f};
                    sbit_reg <= sbit_reg + 4'h1;
                end
                if (sst_reg == adcp_pkg::S_RACK && sda_f) sst_reg <= adcp_pkg::S_IDLE;
            end else if (scl_fall) begin
                case (sst_reg)
                    adcp_pkg::S_ADDR, adcp_pkg::S_WDAT: begin
                        if (sbit_reg == 4'h8) begin
                            sbit_reg <= 4'h0;
                            if (sst_reg == adcp_pkg::S_WDAT || adr_hit) begin
                                ssda_reg <= 1'b1;
                                sst_reg <= adcp_pkg::S_WACK;
                                srd_reg <= (sst_reg == adcp_pkg::S_ADDR) & ssh_reg[0];
                                sbv_reg <= (sst_reg == adcp_pkg::S_WDAT);
                            end else sst_reg <= adcp_pkg::S_IDLE;
                        end
                    end
                    adcp_pkg::S_WACK, adcp_pkg::S_RACK: begin
                        ssda_reg <= 1'b0;
                        sst_reg <= adcp_pkg::S_WDAT;
                        if (srd_reg) begin
                            sst_reg <= adcp_pkg::S_RDAT;
                            ssh_reg <= {rd_w[6:0], 1'b0};
                            ssda_reg <= ~rd_w[7];
                            sbit_reg <= 4'h1;
                        end
                    end
                    adcp_pkg::S_RDAT: begin
                        sbit_reg <= sbit_reg + 4'h1;
                        ssda_reg <= (sbit_reg == 4'h8) ? 1'b0 : ~ssh_reg[7];
                        ssh_reg <= {ssh_reg[6:0], 1'b0};
                        if (sbit_reg == 4'h8) sst_reg <= adcp_pkg::S_RACK;
                    end
                    default: sst_reg <= adcp_pkg::S_IDLE;
                endcase
            end
        end
    end

    // byte parser shared by both engines
    wire       bv_w = sbv_reg | mbv_reg;
    wire [7:0] bd_w = slv_en ? ssh_reg : msh_reg;
    wire       frm_w = slv_en ? (start_w | stop_w) : 1'b0;
    logic       first_reg;
    logic [3:0] pcnt_reg;
    logic       cmt_reg;
    logic [7:0] stg_reg [15];
    wire  [3:0] len_w = blen(sub_reg);
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            first_reg <= 1'b1;
            pcnt_reg <= 4'h0;
            sub_reg <= 8'h00;
            cmt_reg <= 1'b0;
        end else begin
            cmt_reg <= 1'b0;
            if (frm_w) begin
                first_reg <= 1'b1;
                pcnt_reg <= 4'h0;
            end else if (bv_w && first_reg) begin
                first_reg <= 1'b0;
                sub_reg <= bd_w;
            end else if (bv_w && len_w != 4'h0) begin
                stg_reg[pcnt_reg] <= bd_w;
                // commit only on the last byte
                cmt_reg <= (pcnt_reg == len_w - 4'h1);
                pcnt_reg <= (pcnt_reg == len_w - 4'h1) ? 4'h0 : pcnt_reg + 4'h1;
            end
        end
    end

    // control registers
    logic [63:0] comp_reg;
    wire cm_one = cmt_reg && sub_reg == `ADCP_CTL1_OFS;
    wire cm_two = cmt_reg && sub_reg == `ADCP_CTL2_OFS;
    wire cm_cmp = cmt_reg && sub_reg == `ADCP_COMP_OFS;
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            ctl1_reg <= `ADCP_CTL1_RST;
            ctl2_reg <= `ADCP_CTL2_RST;
            comp_reg <= 64'h0;
        end else begin
            if (cm_one) ctl1_reg <= stg_reg[0] & `ADCP_CTL1_WMSK;
            if (cm_two) ctl2_reg <= stg_reg[0] & `ADCP_CTL2_WMSK;
            if (cm_cmp) comp_reg <= {stg_reg[0], stg_reg[1], stg_reg[2], stg_reg[3],
                                     stg_reg[4], stg_reg[5], stg_reg[6], stg_reg[7]};
        end
    end

    logic [23:0] cmem [70];
    wire       bq_r = (sub_reg >= `ADCP_BQR_OFS);
    wire [7:0] bq_s = sub_reg - (bq_r ? `ADCP_BQR_OFS : `ADCP_BQL_OFS);
    wire [6:0] base_w = 7'((bq_s + (bq_r ? 8'(`ADCP_BQ_NUM) : 8'h00)) * 8'h05);
    wire       cm_bq = cmt_reg && len_w == `ADCP_BQ_LEN;
    wire  [23:0] cw_w [5];
    for (g = 0; g < 5; g++) begin : g_coef
        // byte 2 first, integer nibble on top
        assign cw_w[g] = {stg_reg[3*g], stg_reg[3*g+1], stg_reg[3*g+2]};
    end
    always_ff @(posedge clk_i) begin
        if (cm_bq) begin
            for (int k = 0; k < 5; k++) begin
                cmem[base_w + 7'(k)] <= cw_w[k];
            end
        end
    end

    // flat override leaves memory and tone path alone
    wire flat_w = flt_reg[3] | ctl2_reg[`ADCP_AP_BIT];
    // a0 never stored, b0 unity in flat mode
    wire [23:0] cflat = (7'(coef_addr_i % 7'h05) == 7'h00) ? `ADCP_UNITY : 24'h0;
    wire [23:0] cnext = flat_w ? cflat : cmem[coef_addr_i];
    wire signed [48:0] prod = audio_i * $signed({1'b0, comp_scale_i});
    wire signed [28:0] prs = 29'(prod >>> 20);
    wire sat_hi = prs > $signed(29'(`ADCP_SAT_MAX));
    wire sat_lo = prs < -$signed(29'h0800000);
    wire [23:0] anext = sat_hi ? `ADCP_SAT_MAX : sat_lo ? `ADCP_SAT_MIN : prs[23:0];

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            scl_o <= 1'b0;
            sda_o <= 1'b0;
            scl_oe_o <= 1'b0;
            sda_oe_o <= 1'b0;
            coef_o <= 24'h0;
            audio_o <= 24'sh0;
            serial_cfg_o <= '0;
            tone_download_o <= 1'b0;
            flat_eq_o <= 1'b0;
            slave_mode_o <= 1'b0;
            range_compressor_o <= 64'h0;
        end else begin
            scl_o <= 1'b0;
            sda_o <= 1'b0;
            scl_oe_o <= slv_en ? 1'b0 : mscl_reg;
            sda_oe_o <= slv_en ? ssda_reg : msda_reg;
            coef_o <= cnext;
            audio_o <= anext;
            serial_cfg_o <= {ctl1_reg[7:4], ctl1_reg[1:0]};
            tone_download_o <= ctl2_reg[`ADCP_DL_BIT];
            flat_eq_o <= flat_w;
            slave_mode_o <= slv_en;
            range_compressor_o <= comp_reg;
        end
    end

    default clocking @(posedge clk_i); endclocking
    default disable iff (!resetn_i);
    chk_flat_coef_val: assert property (flat_eq_o |-> coef_o inside {24'h0, `ADCP_UNITY})
        else $error("flat coefficient not pass-through");
    chk_sat_high: assert property (sat_hi |=> audio_o == `ADCP_SAT_MAX)
        else $error("positive overflow not clamped");
    chk_comp_whole: assert property ($changed(comp_reg) |-> $past(cm_cmp))
        else $error("compressor changed without full load");
    chk_ctl_one_resv: assert property (ctl1_reg[3:2] == 2'h0)
        else $error("reserved control bits set");
    chk_ctl_two_zero: assert property ((ctl2_reg & 8'h7D) == 8'h00)
        else $error("control two fixed bits nonzero");
    chk_flat_follow: assert property (flat_eq_o == $past(flat_w))
        else $error("flat output lags wrongly");
    chk_slave_fall: assert property ($rose(slv_en) |=> slave_mode_o)
        else $error("slave mode not entered");
    chk_commit_last: assert property (cmt_reg |-> $past(bv_w) && pcnt_reg == 4'h0)
        else $error("commit without final byte");
endmodule : adcp_top

// >>> hdl/adcp_defs.svh
`ifndef ADCP_DEFS_SVH
`define ADCP_DEFS_SVH
// register subaddresses
`define ADCP_CTL1_OFS   8'h01
`define ADCP_CTL2_OFS   8'h43
`define ADCP_COMP_OFS   8'h02
`define ADCP_BQL_OFS    8'h10
`define ADCP_BQR_OFS    8'h20
// reset values and write masks
`define ADCP_CTL1_RST   8'h80
`define ADCP_CTL2_RST   8'h00
`define ADCP_CTL1_WMSK  8'hF3
`define ADCP_CTL2_WMSK  8'h82
// field positions
`define ADCP_LOAD_BIT   7
`define ADCP_BCLK_BIT   6
`define ADCP_DL_BIT     7
`define ADCP_AP_BIT     1
// bus addresses
`define ADCP_SLV_HI     6'h1A
`define ADCP_EE_ADDR    7'h50
// byte counts and biquads per channel
`define ADCP_COMP_LEN   4'h8
`define ADCP_BQ_LEN     4'hF
`define ADCP_BQ_NUM     7
// sample limits and coefficient unity
`define ADCP_UNITY      24'h100000
`define ADCP_SAT_MAX    24'h7FFFFF
`define ADCP_SAT_MIN    24'h800000
// timing: quarter bit time at 100 kbps
`define ADCP_CLK_MHZ    125
`define ADCP_QTR_NS     2500
`define ADCP_QTR_CYC    ((`ADCP_QTR_NS * `ADCP_CLK_MHZ + 999) / 1000)
`endif

// >>> hdl/adcp_pkg.sv
package adcp_pkg;
    typedef enum logic [2:0] {
        S_IDLE = 3'b000,
        S_ADDR = 3'b001,
        S_WACK = 3'b010,
        S_WDAT = 3'b011,
        S_RDAT = 3'b100,
        S_RACK = 3'b101
    } adcp_sst_type;
    typedef enum logic [2:0] {
        M_START = 3'b000,
        M_TX    = 3'b001,
        M_RX    = 3'b010,
        M_STOP  = 3'b011,
        M_OFF   = 3'b100
    } adcp_mst_type;
    typedef struct packed {
        logic       load_speed_select;
        logic       bit_clock_rate_select;
        logic [1:0] fmt;
        logic [1:0] wlen;
    } adcp_scfg_type;
endpackage : adcp_pkg

// >>> verification/adcp_host.sv
module adcp_host #(
    parameter int QTR = 16
) (
    // clock
    input  wire logic clk_i,
    // resolved data line
    input  wire logic sda_i,
    // pull-downs, high = pin low
    output logic      scl_pull_o,
    output logic      sda_pull_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // no eeprom fitted: released lines float high, startup read unanswered
    initial begin
        scl_pull_o = 1'b0;
        sda_pull_o = 1'b0;
    end
    task automatic qtr();
        repeat (QTR) @(posedge clk_i);
        #1;
    endtask : qtr
    // data changes mid low phase, sampled mid high phase
    task automatic bit_x(input logic b, output logic r);
        qtr();
        sda_pull_o = !b;
        qtr();
        scl_pull_o = 1'b0;
        qtr();
        r = sda_i;
        qtr();
        scl_pull_o = 1'b1;
    endtask : bit_x
    task automatic start();
        sda_pull_o = 1'b1;
        qtr();
        scl_pull_o = 1'b1;
    endtask : start
    task automatic stop();
        qtr();
        sda_pull_o = 1'b1;
        qtr();
        scl_pull_o = 1'b0;
        qtr();
        sda_pull_o = 1'b0;
        qtr();
    endtask : stop
    task automatic xfer(input logic [7:0] d, input logic mack, output logic [7:0] r,
                        output logic ack);
        logic b;
        for (int i = 7; i >= 0; i--) begin
            bit_x(d[i], b);
            r = {r[6:0], b};
        end
        bit_x(mack, ack);
    endtask : xfer
    // byte, word and block writes share one framing
    // caller hands the full byte count
    task automatic wr(input logic [7:0] adr, input logic [7:0] dq[$], output logic nak);
        logic [7:0] r;
        logic       a;
        start();
        xfer(adr, 1'b1, r, a);
        nak = a;
        foreach (dq[i]) begin
            xfer(dq[i], 1'b1, r, a);
            nak = nak | a;
        end
        stop();
    endtask : wr
    task automatic rd(input logic [7:0] adr, output logic [7:0] v);
        logic a;
        start();
        xfer(adr, 1'b1, v, a);
        xfer(8'hFF, 1'b1, v, a);
        stop();
    endtask : rd
endmodule : adcp_host

// >>> verification/audio_dsp_control_port_tb.sv
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin n_fail++; $display("wrong value at %0t: got %h want %h", $time, a, e); end end
module audio_dsp_control_port_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic                    clk_i, resetn_i, asel, flat_pin, scl_pull, sda_pull;
    logic                    scl_oe, sda_oe, scl_o, sda_o, tone, flat, slave, nak;
    logic [6:0]              coef_addr;
    logic [23:0]             coef, scale, e;
    logic signed [23:0]      ain, aout;
    adcp_pkg::adcp_scfg_type scfg;
    logic [63:0]             comp, cexp;
    logic [7:0]              m1, m2, b, wa, rv, sub;
    logic [23:0]             cf [70];
    logic [7:0]              q [$];
    longint                  p;
    int                      n_fail, checked, seed, cyc, n_scl;
    wire                     scl_w = !(scl_pull || (scl_oe && !scl_o));
    wire                     sda_w = !(sda_pull || (sda_oe && !sda_o));
    adcp_top #(.EE_BYTES(4)) DUT (
        .clk_i(clk_i), .resetn_i(resetn_i), .scl_i(scl_w), .sda_i(sda_w),
        .scl_o(scl_o), .scl_oe_o(scl_oe), .sda_o(sda_o), .sda_oe_o(sda_oe),
        .address_select_pin_i(asel), .flat_eq_pin_i(flat_pin),
        .coef_addr_i(coef_addr), .coef_o(coef), .audio_i(ain), .comp_scale_i(scale),
        .audio_o(aout), .serial_cfg_o(scfg), .tone_download_o(tone), .flat_eq_o(flat),
        .slave_mode_o(slave), .range_compressor_o(comp));
    adcp_host #(.QTR(16)) host (
        .clk_i(clk_i), .sda_i(sda_w), .scl_pull_o(scl_pull), .sda_pull_o(sda_pull));
    initial begin
        clk_i = 1'b0;
        forever #4 clk_i = ~clk_i;
    end
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 90000) begin
            n_fail++;
            test_done();
        end
    end
    always @(negedge scl_w) begin
        if (slave !== 1'b1) n_scl++;
    end
    task automatic test_done();
        if (n_fail == 0 && checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : test_done
    task automatic chk_cfg();
        `CHK(scfg.load_speed_select, m1[7])
        `CHK(scfg.bit_clock_rate_select, m1[6])
        `CHK(scfg.fmt, m1[5:4])
        `CHK(scfg.wlen, m1[1:0])
        `CHK(tone, m2[7])
        `CHK(flat, m2[1] | flat_pin)
    endtask : chk_cfg
    task automatic chk_coef(input int i, input logic [23:0] x);
        coef_addr = 7'(i);
        repeat (2) @(posedge clk_i);
        #1;
        `CHK(coef, x)
    endtask : chk_coef
    task automatic wr_bq(input logic [7:0] s, input int n);
        int          base;
        logic [23:0] c [5];
        base = (s[5] ? 35 : 0) + 5 * int'(s[2:0]);
        q = {s};
        for (int k = 0; k < 5; k++) begin
            c[k] = 24'($random(seed));
            q.push_back(c[k][23:16]);
            q.push_back(c[k][15:8]);
            q.push_back(c[k][7:0]);
        end
        q = q[0:n];
        host.wr(wa, q, nak);
        `CHK(nak, 1'b0)
        for (int k = 0; k < 5; k++) begin
            if (n == 15) cf[base + k] = c[k];
            chk_coef(base + k, cf[base + k]);
        end
    endtask : wr_bq
    initial begin
        seed = 4;
        {n_fail, checked, cyc, n_scl} = '0;
        {resetn_i, flat_pin, coef_addr, ain, scale} = '0;
        asel = 1'($random(seed));
        wa = {6'h1A, asel, 1'b0};
        m1 = 8'h80;
        m2 = 8'h00;
        repeat (4) @(posedge clk_i);
        #1;
        resetn_i = 1'b1;
        repeat (2) @(posedge clk_i);
        #1;
        chk_cfg();
        for (int i = 0; i < 20000 && slave !== 1'b1; i++) @(posedge clk_i);
        #1;
        `CHK(slave, 1'b1)
        `CHK(n_scl >= 9, 1'b1)
        for (int i = 0; i < 6; i++) begin
            sub = (i < 3) ? 8'h01 : 8'h43;
            b = 8'($random(seed));
            b[1] = i[0];
            q = {sub, b};
            host.wr(wa, q, nak);
            if (i < 3) m1 = b & 8'hF3;
            else m2 = b & 8'h82;
            chk_cfg();
            host.rd(wa | 8'h01, rv);
            `CHK(rv, (i < 3) ? m1 : m2)
        end
        q = {8'h43, 8'h80};
        host.wr(wa, q, nak);
        m2 = 8'h80;
        q = {8'h01, 8'h00};
        host.wr({6'h1A, !asel, 1'b0}, q, nak);
        `CHK(nak, 1'b1)
        chk_cfg();
        wr_bq(8'h10 + 8'({$random(seed)} % 7), 15);
        wr_bq(8'h26, 15);
        wr_bq(8'h26, 6);
        flat_pin = 1'b1;
        repeat (8) @(posedge clk_i);
        #1;
        chk_cfg();
        for (int k = 0; k < 5; k++) chk_coef(65 + k, (k == 0) ? 24'h100000 : 24'h0);
        flat_pin = 1'b0;
        repeat (8) @(posedge clk_i);
        #1;
        for (int k = 0; k < 5; k++) chk_coef(65 + k, cf[65 + k]);
        q = {8'h02, 8'hA5, 8'h5A};
        for (int k = 0; k < 6; k++) q.push_back(8'($random(seed)));
        cexp = {q[1], q[2], q[3], q[4], q[5], q[6], q[7], q[8]};
        host.wr(wa, q, nak);
        `CHK(comp, cexp)
        for (int i = 0; i < 40; i++) begin
            ain = 24'($random(seed));
            scale = 24'($random(seed)) >> (i % 24);
            @(posedge clk_i);
            #1;
            p = (longint'(ain) * longint'({1'b0, scale})) >>> 20;
            e = (p > 64'sd8388607) ? 24'h7FFFFF : (p < -64'sd8388608) ? 24'h800000 : 24'(p);
            `CHK(aout, e)
        end
        test_done();
    end
endmodule : audio_dsp_control_port_tb
